/* File: smcg_admit.sv */
`default_nettype none
module smcg_admit (
   // Request
   input wire smcg_pkg::smcg_cmd_t cmd,
   input wire logic locked,
   input wire logic frozen,
   // Verdict
   output logic allow
);
   import smcg_pkg::*;

   logic abort_locked;
   logic abort_frozen;

   always_comb begin
      abort_locked = 1'b0;
      abort_frozen = 1'b0;
      unique case (cmd)
         cmd_rd_sect, cmd_rd_mult, cmd_rd_dma, cmd_rd_dma_q, cmd_rd_verify: begin
            abort_locked = 1'b1;
         end
         cmd_wr_dma, cmd_wr_dma_q, cmd_wr_mult, cmd_wr_sect: begin
            abort_locked = 1'b1;
         end
         cmd_fc_erase, cmd_fc_wr_mult_noerase, cmd_fc_wr_sect_noerase: begin
            abort_locked = 1'b1;
         end
         cmd_flush_cache, cmd_packet, cmd_service, cmd_set_max: begin
            abort_locked = 1'b1;
         end
         cmd_media_status, cmd_media_eject, cmd_media_lock, cmd_media_unlock: begin
            abort_locked = 1'b1;
         end
         cmd_sec_disable, cmd_sec_set_pw: begin
            abort_locked = 1'b1;
            abort_frozen = 1'b1;
         end
         cmd_sec_freeze: begin
            abort_locked = 1'b1;
         end
         cmd_sec_unlock, cmd_sec_erase_prep, cmd_sec_erase_unit: begin
            abort_frozen = 1'b1;
         end
         default: begin
            // Non-media commands run in every condition
            abort_locked = 1'b0;
            abort_frozen = 1'b0;
         end
      endcase
   end

   // Unlocked condition aborts nothing; frozen aborts only security commands
   assign allow = !((locked && abort_locked) || (frozen && abort_frozen));
endmodule : smcg_admit
`default_nettype wire

/* File: smcg_gate.sv */
`default_nettype none
module smcg_gate (
   // Clock and power-on reset
   input wire logic mclk,
   input wire logic rst_b,
   // Power and reset events
   input wire logic hw_reset_req,
   input wire logic power_down,
   input wire logic power_up,
   input wire logic secured_at_boot,
   // Command request
   input wire logic cmd_valid,
   input wire smcg_pkg::smcg_cmd_t cmd,
   input wire logic pw_match,
   // Command answer
   output logic rsp_valid,
   output logic rsp_abort,
   output logic cmd_go,
   // Status
   output var smcg_pkg::smcg_state_t sec_state,
   output logic attempts_exhausted_flag,
   output logic [smcg_pkg::SMCG_STAT_W-1:0] sec_status
);
   import smcg_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   smcg_state_t state;
   logic [2:0] attempts;
   logic erase_armed;
   logic boot_pending;
   logic awake;
   logic locked;
   logic frozen;
   logic allow;
   logic expired;
   logic pw_cmd;
   logic fail_special;
   logic take;
   logic exec;
   logic unlock_fail;

   assign awake = (state != powered_down_open) && (state != powered_down_secured) && !boot_pending;
   assign locked = (state == secured_locked);
   assign frozen = (state == unlocked_frozen) || (state == open_frozen);
   assign expired = (attempts == SMCG_ATTEMPT_ZERO);
   assign pw_cmd = (cmd == cmd_sec_unlock) || (cmd == cmd_sec_disable) || (cmd == cmd_sec_erase_unit);

   smcg_admit u_admit (
      .cmd(cmd),
      .locked(locked),
      .frozen(frozen),
      .allow(allow)
   );

   // Events outrank commands arriving in the same cycle
   assign take = cmd_valid && awake && !hw_reset_req && !power_down && !power_up;

   always_comb begin
      fail_special = 1'b0;
      if (expired && ((cmd == cmd_sec_unlock) || (cmd == cmd_sec_erase_unit))) begin
         fail_special = 1'b1;
      end else if (pw_cmd && !pw_match) begin
         fail_special = 1'b1;
      end else if ((cmd == cmd_sec_erase_unit) && !erase_armed) begin
         fail_special = 1'b1;
      end
   end

   assign exec = take && allow && !fail_special;
   assign unlock_fail = take && allow && (cmd == cmd_sec_unlock) && !expired && !pw_match;

   // ------------------------------------------------------------
   // Security state
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= open_unfrozen;
         boot_pending <= 1'b1;
      end else if (boot_pending) begin
         // Strap is caught after release, not under reset
         boot_pending <= 1'b0;
         state <= secured_at_boot ? secured_locked : open_unfrozen;
      end else if (hw_reset_req) begin
         unique case (state)
            unlocked_open, unlocked_frozen, secured_locked: state <= secured_locked;
            open_unfrozen, open_frozen: state <= open_unfrozen;
            powered_down_open, powered_down_secured: state <= state;
         endcase
      end else if (power_down) begin
         unique case (state)
            unlocked_open, unlocked_frozen, secured_locked: state <= powered_down_secured;
            open_unfrozen, open_frozen: state <= powered_down_open;
            powered_down_open, powered_down_secured: state <= state;
         endcase
      end else if (power_up) begin
         if (state == powered_down_secured) begin
            state <= secured_locked;
         end else if (state == powered_down_open) begin
            state <= open_unfrozen;
         end
      end else if (exec) begin
         // Aborted commands never reach here, so state stays put
         unique case (cmd)
            cmd_sec_freeze: begin
               if (state == unlocked_open) begin
                  state <= unlocked_frozen;
               end else if (state == open_unfrozen) begin
                  state <= open_frozen;
               end
            end
            cmd_sec_set_pw: begin
               if (state == open_unfrozen) begin
                  state <= unlocked_open;
               end
            end
            cmd_sec_unlock: begin
               if (state == secured_locked) begin
                  state <= unlocked_open;
               end
            end
            cmd_sec_disable: begin
               if (state == unlocked_open) begin
                  state <= open_unfrozen;
               end
            end
            cmd_sec_erase_unit: begin
               if ((state == secured_locked) || (state == unlocked_open)) begin
                  state <= open_unfrozen;
               end
            end
            default: begin
               state <= state;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Erase pairing and attempt counter
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         erase_armed <= 1'b0;
      end else if (hw_reset_req || power_down || power_up) begin
         erase_armed <= 1'b0;
      end else if (take) begin
         // Any command other than the prepare breaks the pair
         erase_armed <= exec && (cmd == cmd_sec_erase_prep);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         attempts <= SMCG_ATTEMPT_LIMIT;
      end else if (hw_reset_req || power_up) begin
         attempts <= SMCG_ATTEMPT_LIMIT;
      end else if (unlock_fail) begin
         attempts <= attempts - 3'h1;
      end
   end

   // ------------------------------------------------------------
   // Answer
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_abort <= 1'b0;
         cmd_go <= 1'b0;
      end else begin
         rsp_valid <= take;
         rsp_abort <= take && !exec;
         cmd_go <= exec;
      end
   end

   assign sec_state = state;
   assign attempts_exhausted_flag = expired;

   always_comb begin
      sec_status = '0;
      sec_status[SMCG_STAT_SUPPORTED] = 1'b1;
      sec_status[SMCG_STAT_ENABLED] = (state == secured_locked) || (state == unlocked_open) ||
                                      (state == unlocked_frozen) || (state == powered_down_secured);
      sec_status[SMCG_STAT_LOCKED] = locked;
      sec_status[SMCG_STAT_FROZEN] = frozen;
      sec_status[SMCG_STAT_EXPIRED] = expired;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic quiet;
   assign quiet = !boot_pending && !hw_reset_req && !power_down && !power_up;

   a_freeze_moves: assert property (
      (quiet && cmd_valid && state == unlocked_open && cmd == cmd_sec_freeze) |=> state == unlocked_frozen)
      else $error("freeze did not reach unlocked frozen");
   a_pdown_secures: assert property (
      (!boot_pending && power_down && !hw_reset_req && (state == unlocked_open || state == unlocked_frozen))
      |=> state == powered_down_secured)
      else $error("power-down did not keep security");
   a_hwreset_locks: assert property (
      (!boot_pending && hw_reset_req && (state == unlocked_open || state == unlocked_frozen))
      |=> state == secured_locked)
      else $error("hardware reset did not lock");
   a_locked_reads_abort: assert property (
      (take && locked && (cmd == cmd_rd_sect || cmd == cmd_rd_dma || cmd == cmd_rd_verify))
      |=> rsp_valid && rsp_abort && !cmd_go)
      else $error("locked read not aborted");
   a_locked_wbuf_runs: assert property (
      (take && locked && (cmd == cmd_wr_buffer || cmd == cmd_standby_imm)) |=> cmd_go && !rsp_abort)
      else $error("locked buffer write refused");
   a_frozen_sec_abort: assert property (
      (take && frozen && (cmd == cmd_sec_unlock || cmd == cmd_sec_set_pw)) |=> rsp_abort ##0 $stable(state))
      else $error("frozen security command accepted");
   a_unlocked_all_run: assert property (
      (take && state == unlocked_open && !pw_cmd && cmd != cmd_sec_erase_unit) |=> cmd_go)
      else $error("unlocked command refused");
   a_unlock_opens: assert property (
      (take && locked && cmd == cmd_sec_unlock && pw_match && !expired) |=> state == unlocked_open)
      else $error("valid unlock ignored");
   // Prepare may sit idle cycles ahead of the unit, so watch the armed flag
   a_erase_pair: assert property (
      (take && cmd == cmd_sec_erase_unit && erase_armed && pw_match && !expired &&
       (locked || state == unlocked_open)) |=> state == open_unfrozen)
      else $error("erase pair did not disable security");
   a_fail_counts: assert property (
      unlock_fail |=> attempts == $past(attempts) - 3'h1 ##0 rsp_abort)
      else $error("failed unlock not counted");
   a_expired_blocks: assert property (
      (take && expired && cmd == cmd_sec_unlock) |=> rsp_abort && state == $past(state))
      else $error("unlock ran after attempts ran out");
   a_abort_keeps: assert property (
      (take && !allow) |=> rsp_abort && !cmd_go && state == $past(state) && attempts == $past(attempts))
      else $error("rejected command changed state");
   a_frozen_rest_runs: assert property (
      (take && frozen && !(cmd inside {cmd_sec_disable, cmd_sec_erase_prep, cmd_sec_erase_unit, cmd_sec_set_pw,
       cmd_sec_unlock})) |=> cmd_go && !rsp_abort)
      else $error("frozen command refused");
   a_frozen_media_run: assert property (
      (take && frozen && (cmd inside {cmd_rd_dma, cmd_wr_sect, cmd_flush_cache, cmd_packet, cmd_service,
       cmd_set_max})) |=> cmd_go)
      else $error("frozen media command refused");
   a_locked_flash_abort: assert property (
      (take && locked && (cmd inside {cmd_fc_erase, cmd_fc_wr_mult_noerase, cmd_fc_wr_sect_noerase}))
      |=> rsp_abort && !cmd_go)
      else $error("locked flash write not aborted");
   a_locked_cache_abort: assert property (
      (take && locked && (cmd inside {cmd_flush_cache, cmd_packet, cmd_service, cmd_set_max})) |=> rsp_abort)
      else $error("locked cache or packet command not aborted");
   a_locked_media_abort: assert property (
      (take && locked && (cmd inside {cmd_media_status, cmd_media_eject, cmd_media_lock, cmd_media_unlock}))
      |=> rsp_abort && !cmd_go)
      else $error("locked media command not aborted");
   a_locked_sec_abort: assert property (
      (take && locked && (cmd inside {cmd_sec_disable, cmd_sec_set_pw, cmd_sec_freeze})) |=> rsp_abort && locked)
      else $error("locked security command accepted");
   a_locked_plain_runs: assert property (
      (take && locked && (cmd inside {cmd_check_power, cmd_dev_reset, cmd_diag, cmd_identify, cmd_idle, cmd_nop,
       cmd_rd_buffer, cmd_rd_native_max, cmd_seek, cmd_set_features, cmd_sleep,
       [cmd_smart_disable:cmd_smart_wr_log]})) |=> cmd_go && !rsp_abort)
      else $error("locked non-media command refused");
   a_disable_opens: assert property (
      (take && state == unlocked_open && cmd == cmd_sec_disable && pw_match) |=> state == open_unfrozen)
      else $error("valid disable left security on");

   c_freeze: cover property (take && exec && cmd == cmd_sec_freeze && state == unlocked_open);
   c_unlock: cover property (take && exec && cmd == cmd_sec_unlock);
   c_erase: cover property (take && exec && cmd == cmd_sec_erase_unit);
   c_attempts_exhausted_flag: cover property (unlock_fail && attempts == 3'h1);
endmodule : smcg_gate
`default_nettype wire

/* File: smcg_host.sv */
`default_nettype none
module smcg_host (
   // Clock
   input wire logic mclk,
   // Command request
   output logic cmd_valid,
   output var smcg_pkg::smcg_cmd_t cmd,
   output logic pw_match,
   // Command answer
   input wire logic rsp_valid,
   input wire logic rsp_abort,
   input wire logic cmd_go
);
   timeunit 1ns;
   timeprecision 1ps;
   import smcg_pkg::*;

   initial begin
      cmd_valid = 1'h0;
      cmd = cmd_nop;
      pw_match = 1'h0;
   end

   // ------------------------------------------------------------
   // One command, strobe for a single cycle
   // ------------------------------------------------------------
   // Ordering of erase prepare and erase unit is the caller's
   task issue(input smcg_cmd_t c, input logic p, output logic rv, output logic ra, output logic go);
      @(posedge mclk);
      cmd_valid <= 1'h1;
      cmd <= c;
      pw_match <= p;
      @(posedge mclk);
      cmd_valid <= 1'h0;
      // Released lines show a different value, never a stale copy
      cmd <= smcg_cmd_t'(~c);
      pw_match <= ~p;
      @(negedge mclk);
      rv = rsp_valid;
      ra = rsp_abort;
      go = cmd_go;
   endtask : issue
endmodule : smcg_host
`default_nettype wire

/* File: smcg_pkg.sv */
`default_nettype none
package smcg_pkg;
   // ------------------------------------------------------------
   // Command set seen by the gate
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      cmd_check_power, cmd_fc_ext_error, cmd_fc_erase, cmd_fc_translate,
      cmd_fc_wr_mult_noerase, cmd_fc_wr_sect_noerase, cmd_dev_reset, cmd_microcode,
      cmd_diag, cmd_flush_cache, cmd_media_status, cmd_identify, cmd_identify_pkt,
      cmd_idle, cmd_idle_imm, cmd_init_params, cmd_media_eject, cmd_media_lock,
      cmd_media_unlock, cmd_nop, cmd_packet, cmd_rd_buffer, cmd_rd_dma,
      cmd_rd_dma_q, cmd_rd_mult, cmd_rd_native_max, cmd_rd_sect, cmd_rd_verify,
      cmd_sec_disable, cmd_sec_erase_prep, cmd_sec_erase_unit, cmd_sec_freeze,
      cmd_sec_set_pw, cmd_sec_unlock, cmd_seek, cmd_service, cmd_set_features,
      cmd_set_max, cmd_set_mult, cmd_sleep, cmd_smart_disable, cmd_smart_autosave,
      cmd_smart_enable, cmd_smart_offline, cmd_smart_rd_data, cmd_smart_rd_log,
      cmd_smart_status, cmd_smart_save, cmd_smart_wr_log, cmd_standby,
      cmd_standby_imm, cmd_wr_buffer, cmd_wr_dma, cmd_wr_dma_q, cmd_wr_mult,
      cmd_wr_sect
   } smcg_cmd_t;

   // ------------------------------------------------------------
   // Security states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      powered_down_open, open_unfrozen, open_frozen, powered_down_secured,
      secured_locked, unlocked_open, unlocked_frozen
   } smcg_state_t;

   // ------------------------------------------------------------
   // Counter and status word layout
   // ------------------------------------------------------------
   localparam logic [2:0] SMCG_ATTEMPT_LIMIT = 3'h5;
   localparam logic [2:0] SMCG_ATTEMPT_ZERO = 3'h0;
   localparam int SMCG_STAT_SUPPORTED = 0;
   localparam int SMCG_STAT_ENABLED = 1;
   localparam int SMCG_STAT_LOCKED = 2;
   localparam int SMCG_STAT_FROZEN = 3;
   localparam int SMCG_STAT_EXPIRED = 4;
   localparam int SMCG_STAT_W = 16;
endpackage : smcg_pkg
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import smcg_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   typedef struct {
      logic [2:0] ev;
      smcg_cmd_t c;
      logic pw;
      logic rv;
      logic ab;
      smcg_state_t st;
      logic fl;
   } smcg_row_t;
   logic mclk = 1'h0;
   logic rst_b = 1'h0;
   logic hw_reset_req = 1'h0, power_down = 1'h0, power_up = 1'h0, secured_at_boot = 1'h1;
   logic cmd_valid, pw_match, rsp_valid, rsp_abort, cmd_go, attempts_exhausted_flag;
   smcg_cmd_t cmd;
   smcg_state_t sec_state;
   logic [SMCG_STAT_W-1:0] sec_status;
   int failures = 0;
   int cmp_count = 0;
   logic rv, ra, go;

   always #10 mclk = ~mclk;

   smcg_gate u_dut (.mclk(mclk), .rst_b(rst_b), .hw_reset_req(hw_reset_req), .power_down(power_down),
      .power_up(power_up), .secured_at_boot(secured_at_boot), .cmd_valid(cmd_valid), .cmd(cmd),
      .pw_match(pw_match), .rsp_valid(rsp_valid), .rsp_abort(rsp_abort), .cmd_go(cmd_go),
      .sec_state(sec_state), .attempts_exhausted_flag(attempts_exhausted_flag), .sec_status(sec_status));
   smcg_host u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd), .pw_match(pw_match),
      .rsp_valid(rsp_valid), .rsp_abort(rsp_abort), .cmd_go(cmd_go));

   // ------------------------------------------------------------
   // Sequence rows: event (4 hw reset, 2 power down, 1 power up, 0 command)
   // ------------------------------------------------------------
   smcg_row_t rows [31] = '{
      '{3'h0, cmd_sec_unlock, 1'h0, 1'h1, 1'h1, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h0, 1'h1, 1'h1, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h0, 1'h1, 1'h1, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h0, 1'h1, 1'h1, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h0, 1'h1, 1'h1, secured_locked, 1'h1},
      '{3'h0, cmd_sec_unlock, 1'h1, 1'h1, 1'h1, secured_locked, 1'h1},
      '{3'h0, cmd_sec_erase_prep, 1'h0, 1'h1, 1'h0, secured_locked, 1'h1},
      '{3'h0, cmd_sec_erase_unit, 1'h1, 1'h1, 1'h1, secured_locked, 1'h1},
      '{3'h4, cmd_nop, 1'h0, 1'h0, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h1, 1'h1, 1'h0, unlocked_open, 1'h0},
      '{3'h2, cmd_nop, 1'h0, 1'h0, 1'h0, powered_down_secured, 1'h0},
      '{3'h0, cmd_nop, 1'h0, 1'h0, 1'h0, powered_down_secured, 1'h0},
      '{3'h1, cmd_nop, 1'h0, 1'h0, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h1, 1'h1, 1'h0, unlocked_open, 1'h0},
      '{3'h0, cmd_sec_freeze, 1'h0, 1'h1, 1'h0, unlocked_frozen, 1'h0},
      '{3'h2, cmd_nop, 1'h0, 1'h0, 1'h0, powered_down_secured, 1'h0},
      '{3'h1, cmd_nop, 1'h0, 1'h0, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_sec_unlock, 1'h1, 1'h1, 1'h0, unlocked_open, 1'h0},
      '{3'h4, cmd_nop, 1'h0, 1'h0, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_sec_erase_prep, 1'h0, 1'h1, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_nop, 1'h0, 1'h1, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_sec_erase_unit, 1'h1, 1'h1, 1'h1, secured_locked, 1'h0},
      '{3'h0, cmd_sec_erase_prep, 1'h0, 1'h1, 1'h0, secured_locked, 1'h0},
      '{3'h0, cmd_sec_erase_unit, 1'h1, 1'h1, 1'h0, open_unfrozen, 1'h0},
      '{3'h0, cmd_sec_set_pw, 1'h0, 1'h1, 1'h0, unlocked_open, 1'h0},
      '{3'h0, cmd_sec_erase_prep, 1'h0, 1'h1, 1'h0, unlocked_open, 1'h0},
      '{3'h0, cmd_sec_erase_unit, 1'h1, 1'h1, 1'h0, open_unfrozen, 1'h0},
      '{3'h0, cmd_sec_set_pw, 1'h0, 1'h1, 1'h0, unlocked_open, 1'h0},
      '{3'h0, cmd_sec_disable, 1'h0, 1'h1, 1'h1, unlocked_open, 1'h0},
      '{3'h0, cmd_sec_disable, 1'h1, 1'h1, 1'h0, open_unfrozen, 1'h0},
      '{3'h0, cmd_sec_set_pw, 1'h0, 1'h1, 1'h0, unlocked_open, 1'h0}
   };

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic gated(smcg_cmd_t c, logic lk, logic fz);
      if (lk) begin
         case (c)
            cmd_fc_erase, cmd_fc_wr_mult_noerase, cmd_fc_wr_sect_noerase, cmd_flush_cache, cmd_media_status,
            cmd_media_eject, cmd_media_lock, cmd_media_unlock, cmd_packet, cmd_rd_dma, cmd_rd_dma_q, cmd_rd_mult,
            cmd_rd_sect, cmd_rd_verify, cmd_sec_disable, cmd_sec_freeze, cmd_sec_set_pw, cmd_service, cmd_set_max,
            cmd_wr_dma, cmd_wr_dma_q, cmd_wr_mult, cmd_wr_sect: return 1'h1;
            default: return 1'h0;
         endcase
      end
      if (fz) begin
         return c inside {cmd_sec_disable, cmd_sec_erase_prep, cmd_sec_erase_unit, cmd_sec_set_pw, cmd_sec_unlock};
      end
      return 1'h0;
   endfunction : gated

   task pulse(input logic [2:0] ev);
      @(posedge mclk);
      {hw_reset_req, power_down, power_up} <= ev;
      @(posedge mclk);
      {hw_reset_req, power_down, power_up} <= 3'h0;
      @(negedge mclk);
   endtask : pulse

   task reset_dut(input logic strap);
      @(posedge mclk);
      rst_b <= 1'h0;
      secured_at_boot <= strap;
      repeat (20) @(posedge mclk);
      rst_b <= 1'h1;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
   endtask : reset_dut

   // Password mismatch also aborts unlock and erase unit, so those fail while locked
   task run_loop(input logic lk, input logic fz, input smcg_state_t st, input logic skip_sec);
      smcg_cmd_t c;
      logic exp;
      for (int i = 0; i <= int'(cmd_wr_sect); i++) begin
         c = smcg_cmd_t'(i);
         if (skip_sec && (c inside {[cmd_sec_disable:cmd_sec_unlock]})) continue;
         u_host.issue(c, 1'h0, rv, ra, go);
         exp = gated(c, lk, fz) || (lk && (c inside {cmd_sec_unlock, cmd_sec_erase_unit}));
         check(c.name(), {rv, ra, go}, {1'h1, exp, ~exp});
         check("sec_state", sec_state, st);
      end
   endtask : run_loop

   task stop_test;
      $display("failures %0d, comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      stop_test();
   end

   initial begin
      reset_dut(1'h1);
      check("boot status", sec_status, 16'h0007);
      foreach (rows[i]) begin
         if (rows[i].ev !== 3'h0) begin
            pulse(rows[i].ev);
         end else begin
            u_host.issue(rows[i].c, rows[i].pw, rv, ra, go);
            check("rsp_valid", rv, rows[i].rv);
            if (rows[i].rv) check("abort/go", {ra, go}, {rows[i].ab, ~rows[i].ab});
         end
         check("row state", sec_state, rows[i].st);
         check("exhausted", attempts_exhausted_flag, rows[i].fl);
         if (i == 5) check("expired status", sec_status, 16'h0017);
      end
      run_loop(1'h0, 1'h0, unlocked_open, 1'h1);
      u_host.issue(cmd_sec_freeze, 1'h0, rv, ra, go);
      check("frozen status", sec_status, 16'h000B);
      run_loop(1'h0, 1'h1, unlocked_frozen, 1'h0);
      pulse(3'h4);
      check("reset from frozen", sec_state, secured_locked);
      run_loop(1'h1, 1'h0, secured_locked, 1'h0);
      reset_dut(1'h0);
      check("open state", sec_state, open_unfrozen);
      check("open status", sec_status, 16'h0001);
      stop_test();
   end
endmodule : tb
`default_nettype wire
